// file: verilog/mcch_pkg.sv
// mcch_pkg: constants for the module configuration command handler
// assumes: nine-word control block presented by the host on ports
package mcch_pkg;
    localparam logic [15:0] OP_RESET    = 16'h0200;
    localparam logic [15:0] OP_SET_IP   = 16'h0201;
    localparam logic [15:0] OP_SET_MASK = 16'h0204;
    localparam logic [15:0] OP_SET_GW   = 16'h0205;
    localparam logic [15:0] OP_PORT_A   = 16'h006f;
    localparam logic [15:0] OP_PORT_B   = 16'h0070;
    localparam logic [15:0] ERR_NONE    = 16'h0000;
    localparam logic [15:0] ERR_ABORT   = 16'h1001;
    localparam logic [15:0] ERR_OPCODE  = 16'h2001;
    localparam logic [15:0] ERR_CHANGED = 16'h2002;
    localparam logic [15:0] ERR_PORT    = 16'h2004;
    localparam logic [15:0] ERR_RANGE   = 16'h2013;
    localparam logic [15:0] ERR_EXC     = 16'h3000;
    localparam logic [15:0] ERR_FORMAT  = 16'h6040;
    localparam logic [15:0] ERR_TIMEOUT = 16'h7001;
    localparam logic [15:0] ERR_INT_A   = 16'h7002;
    localparam logic [15:0] ERR_INT_B   = 16'he001;
    localparam int          FMT_POS     = 8;
    // target module register selects for the backplane write
    localparam logic [1:0]  TGT_CMD     = 2'h0;
    localparam logic [1:0]  TGT_IP      = 2'h1;
    localparam logic [1:0]  TGT_MASK    = 2'h2;
    localparam logic [1:0]  TGT_GW      = 2'h3;
    localparam logic [31:0] CMD_DEFAULT = 32'h00000001;
    // timeout tick: 1/100 s at 100 MHz
    localparam int          CLK_HZ      = 100000000;
    localparam int          TICK_HZ     = 100;
    localparam int          TICK_CYC    = CLK_HZ / TICK_HZ;
    localparam logic [19:0] TICK_MAX    = 20'(TICK_CYC - 1);
    localparam int          NWORDS      = 9;
endpackage

// file: verilog/mcch_bp_if.sv
// mcch_bp_if: timer run, limit and expired signals between handler and tick timer
// assumes: one clock domain
`timescale 1ns/1ps
interface mcch_bp_if;
    logic        run;
    logic [15:0] limit;
    logic        expired;
    modport ctl (output run, output limit, input expired);
    modport tmr (input run, input limit, output expired);
endinterface

// file: verilog/mcch_timer.sv
// mcch_timer: reply timeout counter in hundredths of a second
// assumes: run held high while waiting, dropped to clear
`timescale 1ns/1ps
module mcch_timer #(
    parameter logic [19:0] TICK_LAST = mcch_pkg::TICK_MAX
) (
    input  wire logic clock,
    input  wire logic rstn,
    mcch_bp_if.tmr    tb
);
    logic [19:0] pre_q;
    logic [15:0] hund_q;
    logic        exp_q;
    wire         tick = (pre_q == TICK_LAST);
    wire         hit  = tb.run && (hund_q == tb.limit);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pre_q  <= 20'h00000;
            hund_q <= 16'h0000;
            exp_q  <= 1'b0;
        end else if (!tb.run) begin
            pre_q  <= 20'h00000;
            hund_q <= 16'h0000;
            exp_q  <= 1'b0;
        end else begin
            pre_q  <= tick ? 20'h00000 : pre_q + 20'h00001;
            if (tick && !hit)
                hund_q <= hund_q + 16'h0001;
            exp_q  <= hit;
        end
    end
    assign tb.expired = exp_q;

    AST_TMR_CLEAR: assert property (
        @(posedge clock) disable iff (!rstn)
        !tb.run |=> !tb.expired)
        else $error("timer expired while idle");
endmodule

// file: verilog/mcch_top.sv
// mcch_top: decodes master_instruction_block configuration commands
// assumes: host holds control block stable from start until done
//
// Contract
// - opcode 0x0200 writes factory-default command to target command reg
// - opcode 0x0201 writes ip address, words six to nine, msb first
// - address data sits in the control block itself, read from there
// - opcode 0x0204 writes subnet mask from words six to nine
// - opcode 0x0205 writes default gateway from words six to nine
// - errors as 16-bit codes; 0x1001 aborted, 0x2001 bad opcode
// - control block altered mid-operation reports 0x2002
// - opcodes 111 or 112 with invalid port report 0x2004
// - data block outside host memory reports 0x2013
// - exception response n reports 0x300n
// - badly formatted word n reports 0x6n40
// - no reply before reply timeout reports 0x7001
// - internal faults report 0x7002 or 0xe001
// - reply timeout 0 to 65535 hundredths of a second
`timescale 1ns/1ps
module mcch_top #(
    parameter logic [19:0] TICK_LAST = mcch_pkg::TICK_MAX
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic        abort,
    input  wire logic [15:0] cb_opcode,
    input  wire logic [15:0] cb_slot,
    input  wire logic [15:0] cb_data0,
    input  wire logic [15:0] cb_data1,
    input  wire logic [15:0] cb_data2,
    input  wire logic [15:0] cb_data3,
    input  wire logic        port_bad,
    input  wire logic        range_bad,
    input  wire logic [15:0] reply_timeout,
    input  wire logic        bp_ack,
    input  wire logic        bp_exc,
    input  wire logic [3:0]  bp_exc_code,
    input  wire logic        bp_fault,
    input  wire logic        int_fault,
    output logic             bp_wr,
    output logic [7:0]       bp_slot,
    output logic [1:0]       bp_reg,
    output logic [31:0]      bp_data,
    output logic             busy,
    output logic             done,
    output logic [15:0]      err_status
);
    typedef enum logic [1:0] {IDLE, WAIT} mcch_state_type;
    mcch_state_type state_q;
    logic [15:0] op_q;
    logic [7:0]  slot_q;
    logic [31:0] snap_q;
    logic        wr_q, busy_q, done_q;
    logic [1:0]  reg_q;
    logic [31:0] data_q;
    logic [15:0] err_q;
    logic        fmt_bad;
    logic [3:0]  fmt_idx;

    mcch_bp_if tb ();
    mcch_timer #(.TICK_LAST(TICK_LAST)) u_tmr (
        .clock (clock),
        .rstn  (rstn),
        .tb    (tb)
    );

    ////////////////////////////////////////////////////////////////////
    // decode
    // low byte of slot word is ignored
    wire [7:0]  slot_w = cb_slot[15:8];
    // bytes live in the low byte of words six to nine
    wire [31:0] addr_w = {cb_data0[7:0], cb_data1[7:0],
                          cb_data2[7:0], cb_data3[7:0]};
    wire is_reset = (cb_opcode == mcch_pkg::OP_RESET);
    wire is_ip    = (cb_opcode == mcch_pkg::OP_SET_IP);
    wire is_mask  = (cb_opcode == mcch_pkg::OP_SET_MASK);
    wire is_gw    = (cb_opcode == mcch_pkg::OP_SET_GW);
    wire is_port  = (cb_opcode == mcch_pkg::OP_PORT_A) ||
                    (cb_opcode == mcch_pkg::OP_PORT_B);
    wire is_addr  = is_ip || is_mask || is_gw;
    wire [1:0] reg_w = is_ip   ? mcch_pkg::TGT_IP   :
                       is_mask ? mcch_pkg::TGT_MASK :
                       is_gw   ? mcch_pkg::TGT_GW   : mcch_pkg::TGT_CMD;
    // reset ignores data words, so they never fail format
    wire [31:0] data_w = is_reset ? mcch_pkg::CMD_DEFAULT : addr_w;

    // a data word with a nonzero high byte is malformed; first one wins
    always_comb begin
        fmt_bad = 1'b0;
        fmt_idx = 4'h0;
        if (is_addr && cb_data0[15:8] != 8'h00) begin
            fmt_bad = 1'b1;
            fmt_idx = 4'h5;
        end else if (is_addr && cb_data1[15:8] != 8'h00) begin
            fmt_bad = 1'b1;
            fmt_idx = 4'h6;
        end else if (is_addr && cb_data2[15:8] != 8'h00) begin
            fmt_bad = 1'b1;
            fmt_idx = 4'h7;
        end else if (is_addr && cb_data3[15:8] != 8'h00) begin
            fmt_bad = 1'b1;
            fmt_idx = 4'h8;
        end
    end

    wire [15:0] fmt_err = mcch_pkg::ERR_FORMAT |
                          (16'(fmt_idx) << mcch_pkg::FMT_POS);
    // start-time errors, priority order
    wire [15:0] start_err =
        int_fault  ? mcch_pkg::ERR_INT_A  :
        range_bad  ? mcch_pkg::ERR_RANGE  :
        (is_port && port_bad) ? mcch_pkg::ERR_PORT :
        !(is_reset || is_addr) ? mcch_pkg::ERR_OPCODE :
        fmt_bad    ? fmt_err              : mcch_pkg::ERR_NONE;
    wire start_ok = (start_err == mcch_pkg::ERR_NONE);
    // only the fields the opcode uses are compared
    wire [31:0] live_w = is_reset ? 32'h00000000 : addr_w;
    wire changed = (cb_opcode != op_q) || (slot_w != slot_q) ||
                   (live_w != snap_q);

    wire [15:0] wait_err =
        abort            ? mcch_pkg::ERR_ABORT   :
        changed          ? mcch_pkg::ERR_CHANGED :
        bp_fault         ? mcch_pkg::ERR_INT_B   :
        bp_exc           ? (mcch_pkg::ERR_EXC |
                            16'(bp_exc_code))    :
        tb.expired       ? mcch_pkg::ERR_TIMEOUT :
        mcch_pkg::ERR_NONE;
    wire finish = abort || changed || bp_fault || bp_exc ||
                  tb.expired || bp_ack;

    assign tb.run   = (state_q == WAIT) && !finish;
    assign tb.limit = reply_timeout;

    ////////////////////////////////////////////////////////////////////
    // control
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= IDLE;
            op_q    <= 16'h0000;
            slot_q  <= 8'h00;
            snap_q  <= 32'h00000000;
            wr_q    <= 1'b0;
            reg_q   <= 2'h0;
            data_q  <= 32'h00000000;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
            err_q   <= 16'h0000;
        end else begin
            wr_q   <= 1'b0;
            done_q <= 1'b0;
            case (state_q)
                IDLE: begin
                    if (start && start_ok) begin
                        state_q <= WAIT;
                        op_q    <= cb_opcode;
                        slot_q  <= slot_w;
                        snap_q  <= live_w;
                        wr_q    <= 1'b1;
                        reg_q   <= reg_w;
                        data_q  <= data_w;
                        busy_q  <= 1'b1;
                        err_q   <= mcch_pkg::ERR_NONE;
                    end else if (start) begin
                        done_q  <= 1'b1;
                        err_q   <= start_err;
                    end
                end
                WAIT: begin
                    if (finish) begin
                        state_q <= IDLE;
                        busy_q  <= 1'b0;
                        done_q  <= 1'b1;
                        err_q   <= wait_err;
                    end
                end
                default: state_q <= IDLE;
            endcase
        end
    end

    assign bp_wr      = wr_q;
    assign bp_slot    = slot_q;
    assign bp_reg     = reg_q;
    assign bp_data    = data_q;
    assign busy       = busy_q;
    assign done       = done_q;
    assign err_status = err_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    AST_RESET_WR: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == IDLE && start && start_ok && is_reset) |=>
        bp_wr && bp_reg == 2'h0 && bp_data == 32'h00000001)
        else $error("factory reset write missing");
    AST_IP_DATA: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == IDLE && start && start_ok && is_ip) |=>
        bp_wr && bp_reg == 2'h1 &&
        bp_data[31:24] == $past(cb_data0[7:0]))
        else $error("ip byte order wrong");
    AST_MASK_REG: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == IDLE && start && start_ok && is_mask) |=>
        bp_reg == 2'h2 && bp_data[7:0] == $past(cb_data3[7:0]))
        else $error("mask write wrong");
    AST_GW_REG: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == IDLE && start && start_ok && is_gw) |=>
        bp_reg == 2'h3)
        else $error("gateway write wrong");
    AST_SLOT: assert property (@(posedge clock) disable iff (!rstn)
        bp_wr |-> bp_slot == $past(cb_slot[15:8]))
        else $error("slot not from high byte");
    AST_BAD_OP: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == IDLE && start && !int_fault && !range_bad &&
         !is_port && !is_reset && !is_addr) |=>
        done && err_status == 16'h2001 && !busy)
        else $error("unsupported opcode not reported");
    AST_ABORT: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == WAIT && abort) |=> done && err_status == 16'h1001)
        else $error("abort not reported");
    AST_CHANGED: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == WAIT && !abort && changed) |=>
        done && err_status == 16'h2002)
        else $error("changed block not reported");
    AST_EXC: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == WAIT && bp_exc && !abort && !changed && !bp_fault)
        |=> err_status == {12'h300, $past(bp_exc_code)})
        else $error("exception code wrong");
    AST_OK_ZERO: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == WAIT && bp_ack && !abort && !changed && !bp_fault &&
         !bp_exc && !tb.expired) |=> done && err_status == 16'h0000)
        else $error("success left nonzero status");
endmodule

// file: verif/mcch_target_model.sv
// mcch_target_model: target option module answering backplane writes
// assumes: one write outstanding at a time, answer after delay+1 cycles
`timescale 1ns/1ps
module mcch_target_model (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       bp_wr,
    input  wire logic [1:0] mode,
    input  wire logic [3:0] delay,
    input  wire logic [3:0] exc_code,
    output logic            bp_ack,
    output logic            bp_exc,
    output logic [3:0]      bp_exc_code,
    output logic            bp_fault
);
    logic [4:0] cnt_q;
    // code line shows inverse outside its pulse so stale values never pass
    assign bp_exc_code = bp_exc ? exc_code : ~exc_code;
    ////////////////////////////////////////////////////////////////////////
    // mode 0 ack, 1 exception, 2 fault, 3 silent (lets timeout run)
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_q    <= 5'h00;
            bp_ack   <= 1'b0;
            bp_exc   <= 1'b0;
            bp_fault <= 1'b0;
        end else begin
            bp_ack   <= 1'b0;
            bp_exc   <= 1'b0;
            bp_fault <= 1'b0;
            if (bp_wr) begin
                cnt_q <= {1'b0, delay} + 5'h01;
            end else if (cnt_q != 5'h00) begin
                cnt_q <= cnt_q - 5'h01;
                if (cnt_q == 5'h01) begin
                    bp_ack   <= (mode == 2'h0);
                    bp_exc   <= (mode == 2'h1);
                    bp_fault <= (mode == 2'h2);
                end
            end
        end
    end
endmodule

// file: verif/test_module_config_command_handler.sv
// test_module_config_command_handler: self-checking bench for mcch_top
// assumes: mcch_target_model on the backplane side, short tick in sim
`timescale 1ns/1ps
module test_module_config_command_handler;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        start = 1'b0;
    logic        abort = 1'b0;
    logic        port_bad = 1'b0;
    logic        range_bad = 1'b0;
    logic        int_fault = 1'b0;
    logic [15:0] opc = 16'h0000;
    logic [15:0] slot = 16'h0000;
    logic [15:0] d [4] = '{default: 16'h0000};
    logic [15:0] rto = 16'h0002;
    logic [1:0]  mode = 2'h0;
    logic [3:0]  dly = 4'h0;
    logic [3:0]  xc = 4'h0;
    logic        bp_ack, bp_exc, bp_fault, bp_wr, busy, done;
    logic [3:0]  bp_exc_code;
    logic [7:0]  bp_slot;
    logic [1:0]  bp_reg;
    logic [31:0] bp_data;
    logic [15:0] err_status;
    int          err_count = 0;
    int          cmp_count = 0;
    always #5 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    // tick of 10 cycles keeps timeouts short
    mcch_top #(.TICK_LAST(20'h00009)) u_dut (
        .clock(clock), .rstn(rstn), .start(start), .abort(abort),
        .cb_opcode(opc), .cb_slot(slot), .cb_data0(d[0]),
        .cb_data1(d[1]), .cb_data2(d[2]), .cb_data3(d[3]),
        .port_bad(port_bad), .range_bad(range_bad),
        .reply_timeout(rto), .bp_ack(bp_ack), .bp_exc(bp_exc),
        .bp_exc_code(bp_exc_code), .bp_fault(bp_fault),
        .int_fault(int_fault), .bp_wr(bp_wr), .bp_slot(bp_slot),
        .bp_reg(bp_reg), .bp_data(bp_data), .busy(busy), .done(done),
        .err_status(err_status));
    mcch_target_model u_tgt (
        .clock(clock), .rstn(rstn), .bp_wr(bp_wr), .mode(mode),
        .delay(dly), .exc_code(xc), .bp_ack(bp_ack), .bp_exc(bp_exc),
        .bp_exc_code(bp_exc_code), .bp_fault(bp_fault));
    ////////////////////////////////////////////////////////////////////////
    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task cb(input logic [15:0] o, s, a, b, c, f);
        opc  = o;
        slot = s;
        d    = '{a, b, c, f};
    endtask
    // act 1 raises abort, act 2 alters the opcode while waiting
    task go(input logic [15:0] e, input logic w, input logic [1:0] r,
            input logic [31:0] v, input int act, input int lo);
        int   n;
        int   wr;
        logic seen;
        n = 0;
        wr = 0;
        seen = 1'b0;
        @(negedge clock) start = 1'b1;
        @(negedge clock) start = 1'b0;
        while (!seen && n < 400) begin
            if (bp_wr === 1'b1) begin
                wr++;
                chk("busy", 32'h1, {31'h0, busy});
            end
            if (done === 1'b1) begin
                seen = 1'b1;
            end else begin
                if (n == 3 && act == 1) abort = 1'b1;
                if (n == 3 && act == 2) opc = opc ^ 16'h0001;
                n++;
                @(negedge clock);
            end
        end
        if (!seen) begin
            err_count++;
            $display("Error done expected 1 seen 0");
            tally_and_finish;
        end
        @(negedge clock) abort = 1'b0;
        chk("done pulse", 32'h0, {31'h0, done});
        chk("busy after", 32'h0, {31'h0, busy});
        chk("err_status", {16'h0, e}, {16'h0, err_status});
        chk("bp_wr count", {31'h0, w}, 32'(wr));
        chk("done time", 32'h1, {31'h0, n >= lo});
        if (w) begin
            chk("bp_reg", {30'h0, r}, {30'h0, bp_reg});
            chk("bp_data", v, bp_data);
            chk("bp_slot", {24'h0, slot[15:8]}, {24'h0, bp_slot});
        end
        $display("op %h finished", opc);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(negedge clock);
        chk("reset err_status", 32'h0, {16'h0, err_status});
        chk("reset busy", 32'h0, {31'h0, busy | done | bp_wr});
        rstn = 1'b1;
        cb(mcch_pkg::OP_RESET, 16'h04a5, 16'h1234, 16'h5678, 16'h9abc,
           16'hdef0);
        go(mcch_pkg::ERR_NONE, 1, mcch_pkg::TGT_CMD,
           mcch_pkg::CMD_DEFAULT, 0, 0);
        cb(mcch_pkg::OP_SET_IP, 16'h0500, 16'h00c0, 16'h00a8, 16'h0000,
           16'h000a);
        dly = 4'h6;
        go(mcch_pkg::ERR_NONE, 1, mcch_pkg::TGT_IP, 32'hc0a8000a,
           0, 6);
        dly = 4'h0;
        cb(mcch_pkg::OP_SET_MASK, 16'h0500, 16'h00ff, 16'h00ff, 16'h0000,
           16'h0000);
        go(mcch_pkg::ERR_NONE, 1, mcch_pkg::TGT_MASK, 32'hffff0000,
           0, 0);
        cb(mcch_pkg::OP_SET_GW, 16'h0300, 16'h00c0, 16'h00a8, 16'h0000,
           16'h0001);
        go(mcch_pkg::ERR_NONE, 1, mcch_pkg::TGT_GW, 32'hc0a80001,
           0, 0);
        cb(16'h0203, 16'h0500, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        go(mcch_pkg::ERR_OPCODE, 0, 2'h0, 32'h0, 0, 0);
        mode = 2'h3;
        cb(mcch_pkg::OP_SET_IP, 16'h0200, 16'h00c0, 16'h00a8, 16'h0000,
           16'h000a);
        go(mcch_pkg::ERR_ABORT, 1, mcch_pkg::TGT_IP, 32'hc0a8000a,
           1, 0);
        go(mcch_pkg::ERR_CHANGED, 1, mcch_pkg::TGT_IP, 32'hc0a8000a,
           2, 0);
        port_bad = 1'b1;
        cb(mcch_pkg::OP_PORT_A, 16'h0500, 16'h0000, 16'h0000, 16'h0000,
           16'h0000);
        go(mcch_pkg::ERR_PORT, 0, 2'h0, 32'h0, 0, 0);
        opc = mcch_pkg::OP_PORT_B;
        go(mcch_pkg::ERR_PORT, 0, 2'h0, 32'h0, 0, 0);
        port_bad = 1'b0;
        go(mcch_pkg::ERR_OPCODE, 0, 2'h0, 32'h0, 0, 0);
        range_bad = 1'b1;
        cb(mcch_pkg::OP_SET_IP, 16'h0500, 16'h00c0, 16'h00a8, 16'h0000,
           16'h000a);
        go(mcch_pkg::ERR_RANGE, 0, 2'h0, 32'h0, 0, 0);
        range_bad = 1'b0;
        mode = 2'h1;
        xc = 4'h5;
        go(mcch_pkg::ERR_EXC | 16'h0005, 1, mcch_pkg::TGT_IP,
           32'hc0a8000a, 0, 0);
        mode = 2'h3;
        go(mcch_pkg::ERR_TIMEOUT, 1, mcch_pkg::TGT_IP, 32'hc0a8000a,
           0, 20);
        // zero hundredths expires one cycle after the wait begins
        rto = 16'h0000;
        go(mcch_pkg::ERR_TIMEOUT, 1, mcch_pkg::TGT_IP, 32'hc0a8000a,
           0, 2);
        // restore a real timeout so the fault below wins the race
        rto = 16'h0002;
        mode = 2'h2;
        go(mcch_pkg::ERR_INT_B, 1, mcch_pkg::TGT_IP, 32'hc0a8000a,
           0, 0);
        int_fault = 1'b1;
        go(mcch_pkg::ERR_INT_A, 0, 2'h0, 32'h0, 0, 0);
        int_fault = 1'b0;
        d[1] = 16'h01a8;
        go(mcch_pkg::ERR_FORMAT | (16'h0006 << mcch_pkg::FMT_POS), 0, 2'h0,
           32'h0, 0, 0);
        tally_and_finish;
    end
endmodule
